// ---- logic/ses_consts.vh ----
// constants for the serial eeprom select and write-start block
// assumes a 100 MHz system clock and an external spi host
`ifndef SES_CONSTS_VH
`define SES_CONSTS_VH
`define SES_CLK_MHZ 100
`define SES_WRITE_MS 5
`define SES_WRITE_CYCLES (`SES_WRITE_MS * 1000 * `SES_CLK_MHZ)
`define SES_OP_READ 8'h03
`define SES_OP_WRITE 8'h02
`define SES_OP_LATCH_EN 8'h06
`define SES_BITS_OP 4'h8
`define SES_BITS_ADDR 5'h18
`define SES_PH_IDLE 2'h0
`define SES_PH_OP 2'h1
`define SES_PH_ADDR 2'h2
`define SES_PH_DATA 2'h3
`endif

// ---- logic/ses_select_write.v ----
// chip select, serial output control and write-cycle start for a spi eeprom slave
// assumes pins arrive asynchronously; array data enters through a two-entry buffer
`timescale 1ns/1ps
`include "ses_consts.vh"

module ses_select_write #(
    parameter WRITE_CYCLES = `SES_WRITE_CYCLES
) (
    input wire clk_sys,
    input wire rst_b,
    input wire cs_b,
    input wire sck,
    input wire si,
    input wire pause_b,
    input wire [7:0] rd_data,
    input wire rd_valid,
    output reg rd_ready,
    output reg so_out,
    output reg so_oe,
    output reg standby,
    output reg busy,
    output reg write_latch,
    output reg write_start,
    output reg [12:0] addr,
    output reg rd_req
);
    // two-flop synchronisers for every pin
    reg [1:0] cs_s, sck_s, si_s, pause_s;
    reg sck_d;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cs_s <= 2'h3;
            sck_s <= 2'h0;
            si_s <= 2'h0;
            pause_s <= 2'h3;
            sck_d <= 1'b0;
        end else begin
            cs_s <= {cs_s[0], cs_b};
            sck_s <= {sck_s[0], sck};
            si_s <= {si_s[0], si};
            pause_s <= {pause_s[0], pause_b};
            sck_d <= sck_s[1];
        end
    end
    wire cs_n = cs_s[1];
    wire sck_rise = sck_s[1] & ~sck_d;
    wire sck_fall = ~sck_s[1] & sck_d;
    wire held = ~pause_s[1];
    reg cs_d;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) cs_d <= 1'b1;
        else cs_d <= cs_n;
    end
    wire cs_rise = cs_n & ~cs_d;

    // two-entry buffer holding array bytes for the read path
    reg [7:0] buf_mem [0:1];
    reg buf_wp, buf_rp;
    reg [1:0] buf_cnt;
    wire buf_full = (buf_cnt == 2'h2);
    wire buf_empty = (buf_cnt == 2'h0);
    reg buf_pop;
    // a byte is taken only on a valid and ready handshake, or the source would repeat it
    wire buf_push = rd_valid & rd_ready & ~buf_full;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            rd_ready <= 1'b0;
        end else begin
            if (buf_push) begin
                buf_mem[buf_wp] <= rd_data;
                buf_wp <= ~buf_wp;
            end
            if (buf_pop & ~buf_empty) buf_rp <= ~buf_rp;
            case ({buf_push, buf_pop & ~buf_empty})
                2'b10: buf_cnt <= buf_cnt + 2'h1;
                2'b01: buf_cnt <= buf_cnt - 2'h1;
                default: buf_cnt <= buf_cnt;
            endcase
            // ready drops in the same cycle the buffer fills so no byte is lost
            rd_ready <= (buf_cnt == 2'h0) | ((buf_cnt == 2'h1) & ~buf_push);
        end
    end

    // serial front end
    reg armed;
    reg [1:0] phase;
    reg [4:0] bit_cnt;
    reg [7:0] shift_in;
    reg [7:0] opcode;
    reg [7:0] shift_out;
    reg [2:0] out_cnt;
    reg data_byte_seen;
    reg op_complete;
    reg [31:0] wr_timer;
    wire selected = ~cs_n & ~busy & armed;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
            phase <= `SES_PH_IDLE;
            bit_cnt <= 5'h0;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            shift_out <= 8'h00;
            out_cnt <= 3'h0;
            data_byte_seen <= 1'b0;
            op_complete <= 1'b0;
            addr <= 13'h0000;
            rd_req <= 1'b0;
            buf_pop <= 1'b0;
            so_out <= 1'b0;
        end else begin
            buf_pop <= 1'b0;
            rd_req <= 1'b0;
            if (!cs_n) armed <= 1'b1;
            if (!selected || cs_n) begin
                phase <= `SES_PH_IDLE;
                bit_cnt <= 5'h0;
                out_cnt <= 3'h0;
                if (cs_n) begin
                    data_byte_seen <= 1'b0;
                    op_complete <= 1'b0;
                end
            end else if (!held) begin
                if (phase == `SES_PH_IDLE) phase <= `SES_PH_OP;
                if (sck_rise) begin
                    shift_in <= {shift_in[6:0], si_s[1]};
                    bit_cnt <= bit_cnt + 5'h1;
                    case (phase)
                        `SES_PH_IDLE, `SES_PH_OP: begin
                            if (bit_cnt == `SES_BITS_OP - 5'h1) begin
                                opcode <= {shift_in[6:0], si_s[1]};
                                op_complete <= 1'b1;
                                bit_cnt <= 5'h0;
                                phase <= `SES_PH_ADDR;
                            end
                        end
                        `SES_PH_ADDR: begin
                            addr <= {addr[11:0], si_s[1]};
                            if (bit_cnt == `SES_BITS_ADDR - 5'h1) begin
                                bit_cnt <= 5'h0;
                                phase <= `SES_PH_DATA;
                                rd_req <= (opcode == `SES_OP_READ);
                            end
                        end
                        `SES_PH_DATA: begin
                            if (bit_cnt[2:0] == 3'h7) begin
                                data_byte_seen <= 1'b1;
                                bit_cnt <= 5'h0;
                            end
                        end
                        default: phase <= `SES_PH_IDLE;
                    endcase
                end
                // output shifts after the falling clock edge
                if (sck_fall && phase == `SES_PH_DATA && opcode == `SES_OP_READ) begin
                    if (out_cnt == 3'h0) begin
                        so_out <= buf_mem[buf_rp][7];
                        shift_out <= {buf_mem[buf_rp][6:0], 1'b0};
                        buf_pop <= 1'b1;
                        addr <= addr + 13'h0001;
                        rd_req <= 1'b1;
                    end else begin
                        so_out <= shift_out[7];
                        shift_out <= {shift_out[6:0], 1'b0};
                    end
                    out_cnt <= out_cnt + 3'h1;
                end
            end
        end
    end

    // output enable: deselect or pause forces high impedance
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) so_oe <= 1'b0;
        else so_oe <= selected & ~held & ~cs_s[1];
    end

    // latch, write start and write-cycle timer
    wire valid_write = (opcode == `SES_OP_WRITE) & data_byte_seen & write_latch;
    // standby must see a start in its own cycle, or it would rise beside busy
    wire write_go = cs_rise & ~busy & armed & valid_write;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            write_latch <= 1'b0;
            write_start <= 1'b0;
            busy <= 1'b0;
            wr_timer <= 32'h0;
            standby <= 1'b1;
        end else begin
            write_start <= 1'b0;
            if (cs_rise && !busy && armed) begin
                if (op_complete && opcode == `SES_OP_LATCH_EN) begin
                    write_latch <= 1'b1;
                end else if (valid_write) begin
                    write_start <= 1'b1;
                    busy <= 1'b1;
                    wr_timer <= 32'h0;
                    write_latch <= 1'b0;
                end
            end
            if (busy) begin
                // counter runs regardless of select level
                if (wr_timer == WRITE_CYCLES - 1) busy <= 1'b0;
                else wr_timer <= wr_timer + 32'h1;
            end
            standby <= cs_n & ~busy & ~write_start & ~write_go;
        end
    end
endmodule // ses_select_write

// ---- tb/ses_select_write_props.sv ----
// assertions on the select, serial output and write-start ports
// bound onto the design from the bench top; one clock domain
`timescale 1ns/1ps
module ses_select_write_props #(parameter WRITE_CYCLES = 50) (
    input wire clk_sys,
    input wire rst_b,
    input wire cs_b,
    input wire pause_b,
    input wire so_oe,
    input wire standby,
    input wire busy,
    input wire write_latch,
    input wire write_start
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // length of the current busy span, so the write time can be bounded
    reg [31:0] busy_n;
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) busy_n <= 32'h0;
        else busy_n <= busy ? busy_n + 32'h1 : 32'h0;
    end
    a_oe_desel: assert property (cs_b [*5] |-> !so_oe) else $error("so driven");
    a_oe_pause: assert property (!pause_b [*5] |-> !so_oe) else $error("so in pause");
    a_sby_sel: assert property (!cs_b [*5] |-> !standby) else $error("standby while on");
    a_sby_busy: assert property (busy |-> !standby) else $error("standby in write");
    a_start_busy: assert property (write_start |=> busy) else $error("no busy");
    a_start_rise: assert property (write_start |-> cs_b) else $error("start while on");
    a_busy_held: assert property ($rose(busy) |-> busy [*8]) else $error("write cut");
    a_busy_len: assert property (busy_n <= WRITE_CYCLES) else $error("write long");
    a_busy_cause: assert property ($rose(busy) |-> write_start) else $error("busy without start");
    a_latch_used: assert property (write_start |=> !write_latch) else $error("latch kept");
endmodule // ses_select_write_props

// ---- tb/ses_spi_host.sv ----
// spi host model: drives select, clock and data, samples serial output
// paced by the bench clock; sck stands low between frames
`timescale 1ns/1ps
module ses_spi_host (
    input wire clk_sys,
    input wire so_out,
    input wire so_oe,
    output reg cs_b,
    output reg sck,
    output reg si
);
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // one byte msb first, 80 ns a bit; so taken late in the high phase, well after it moved
    task xbyte(input [7:0] v, output [7:0] got);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                si <= v[i];
                repeat (4) @(posedge clk_sys);
                sck <= 1'b1;
                repeat (4) @(posedge clk_sys);
                got[i] = so_oe ? so_out : ~si;
                sck <= 1'b0;
            end
        end
    endtask
    // select or release; si flips on each change so a stale level is never trusted
    task sel(input on);
        begin
            @(posedge clk_sys);
            cs_b <= ~on;
            si <= ~si;
            repeat (6) @(posedge clk_sys);
        end
    endtask
endmodule // ses_spi_host

// ---- tb/ses_select_write_tb.sv ----
// self-checking bench for the spi eeprom select and write-start block
// host model on the serial pins; the bench feeds the array-side buffer
`timescale 1ns/1ps
module ses_select_write_tb;
    reg clk_sys;
    reg rst_b;
    reg pause_b;
    reg rd_valid;
    reg [7:0] rd_data;
    reg [7:0] g;
    reg [31:0] n_req = 32'h0;
    reg [31:0] n_start = 32'h0;
    reg [31:0] n_busy = 32'h0;
    integer fails = 0;
    integer n_checks = 0;
    integer k;
    wire cs_b, sck, si, rd_ready, so_out, so_oe, standby, busy, write_latch, write_start, rd_req;
    wire [12:0] addr;
    always #5 clk_sys = ~clk_sys;
    // next array byte once the buffer takes one; also count starts and busy cycles
    always @(posedge clk_sys) begin
        if (rd_valid && rd_ready) rd_data <= rd_data + 8'h01;
        if (write_start) n_start <= n_start + 32'h1;
        if (rd_req) n_req <= n_req + 32'h1;
        if (busy) n_busy <= n_busy + 32'h1;
    end
    ses_spi_host host_u (.clk_sys(clk_sys), .so_out(so_out), .so_oe(so_oe), .cs_b(cs_b),
        .sck(sck), .si(si));
    ses_select_write #(.WRITE_CYCLES(50)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b),
        .sck(sck), .si(si), .pause_b(pause_b), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .so_out(so_out), .so_oe(so_oe), .standby(standby), .busy(busy),
        .write_latch(write_latch), .write_start(write_start), .addr(addr), .rd_req(rd_req));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // read across the top address: buffer full beforehand, bytes in order, pause, release
    task t_read;
        begin
            rd_valid <= 1'b1;
            host_u.sel(1'b1);
            host_u.xbyte(8'h03, g);
            host_u.xbyte(8'h00, g);
            host_u.xbyte(8'h1f, g);
            host_u.xbyte(8'hfe, g);
            chk(addr, 32'h1ffe);
            chk(rd_ready, 32'h0);
            for (k = 0; k < 3; k = k + 1) begin
                host_u.xbyte(8'h00, g);
                chk(g, 32'ha5 + k);
            end
            chk(addr, 32'h0001);
            chk(n_req, 32'h4);
            chk(so_oe, 32'h1);
            pause_b <= 1'b0;
            repeat (6) @(posedge clk_sys);
            chk(so_oe, 32'h0);
            pause_b <= 1'b1;
            rd_valid <= 1'b0;
            host_u.sel(1'b0);
            chk(so_oe, 32'h0);
            chk(standby, 32'h1);
        end
    endtask
    // latch only on the select rise after the whole instruction
    task t_latch;
        begin
            host_u.sel(1'b1);
            host_u.xbyte(8'h06, g);
            chk(write_latch, 32'h0);
            host_u.sel(1'b0);
            chk(write_latch, 32'h1);
        end
    endtask
    task w_seq;
        begin
            host_u.sel(1'b1);
            host_u.xbyte(8'h02, g);
            for (k = 0; k < 4; k = k + 1) host_u.xbyte(8'h40, g);
            host_u.sel(1'b0);
        end
    endtask
    // write, select toggled mid-cycle, then a second write with the latch clear
    task t_write;
        begin
            w_seq;
            chk(n_start, 32'h1);
            chk(write_latch, 32'h0);
            host_u.sel(1'b1);
            host_u.sel(1'b0);
            chk(standby, 32'h0);
            for (k = 0; busy && k < 200; k = k + 1) @(posedge clk_sys);
            repeat (6) @(posedge clk_sys);
            chk(n_busy, 32'd50);
            chk(n_start, 32'h1);
            chk(standby, 32'h1);
            w_seq;
            chk(n_start, 32'h1);
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        pause_b = 1'b1;
        rd_valid = 1'b0;
        rd_data = 8'ha5;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_read;
        t_latch;
        t_write;
        results;
    end
    // watchdog: the tests need about 1300 cycles
    initial begin
        repeat (8000) @(posedge clk_sys);
        fails = fails + 1;
        results;
    end
endmodule // ses_select_write_tb
bind ses_select_write ses_select_write_props #(.WRITE_CYCLES(WRITE_CYCLES)) props_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .pause_b(pause_b), .so_oe(so_oe),
    .standby(standby), .busy(busy), .write_latch(write_latch), .write_start(write_start));
